// file: hdl/aewb_ctrl.v
// Region, metering and loop logic for auto exposure and colour balance.
// Expects a linear (pre-gamma) RGB pixel stream with coordinates and a
// one-cycle frame end pulse; pixels arrive already scaled by the current
// channel ratios. Registers are reached over Avalon-MM with waitrequest.
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`include "aewb_defines.vh"

module aewb_ctrl (
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire [6:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire        pix_valid_i,
  input  wire [11:0] pix_x_i,
  input  wire [11:0] pix_y_i,
  input  wire [7:0]  pix_r_i,
  input  wire [7:0]  pix_g_i,
  input  wire [7:0]  pix_b_i,
  input  wire        frame_end_i,
  output reg  [19:0] exposure_o,
  output reg  [8:0]  gain_o,
  output reg  [11:0] red_ratio_o,
  output reg  [11:0] blue_ratio_o,
  output reg         update_o
);
  // ****************************************************************
  // settings
  // ****************************************************************
  reg        sel_q, selfset_q, profile_q;
  reg [1:0]  light_q;
  reg [2:0]  meter_q;
  reg        reg_en_q    [0:1];
  reg [11:0] reg_left_q  [0:1];
  reg [11:0] reg_top_q   [0:1];
  reg [11:0] reg_cols_q  [0:1];
  reg [11:0] reg_rows_q  [0:1];
  reg [11:0] frame_cols_q, frame_rows_q;
  reg [11:0] ratio_min_q, ratio_max_q;
  reg [2:0]  damping_q;
  reg [6:0]  target_q;
  reg [6:0]  tgt_min_q, tgt_max_q;
  reg [19:0] exp_min_q, exp_max_q;
  reg [8:0]  gain_min_q, gain_max_q;
  reg [6:0]  tgt_now_q;
  reg [33:0] ae_sum_q;
  reg [25:0] ae_cnt_q;
  reg [31:0] r_sum_q, g_sum_q, b_sum_q;
  wire rd_take = avs_read_i & ~avs_waitrequest_o;
  wire wr_take = avs_write_i & ~avs_waitrequest_o;
  integer i;
  function in_win;
    input [11:0] x, y, x0, y0, w, h;
    begin
      in_win = ({1'b0, x} >= {1'b0, x0}) && ({1'b0, x} < x0 + {1'b0, w}) &&
               ({1'b0, y} >= {1'b0, y0}) && ({1'b0, y} < y0 + {1'b0, h});
    end
  endfunction
  function [11:0] frac;
    input [11:0] v;
    input [6:0]  m;
    reg   [18:0] p;
    begin
      p = v * m;
      frac = {1'b0, p[18:8]};
    end
  endfunction
  // ratio limits, a wrapped step saturates at the near end
  function [11:0] ratio_next;
    input [11:0] cur, step, lo, hi;
    input        up, dn;
    reg   [12:0] t;
    begin
      t = {1'b0, cur};
      if (up)
        t = {1'b0, cur} + {1'b0, step};
      else if (dn)
        t = {1'b0, cur} - {1'b0, step};
      ratio_next = t[11:0];
      if (t[12] & cur[11])
        ratio_next = hi;
      else if (t[12] | (t[11:0] < lo))
        ratio_next = lo;
      else if (t[11:0] > hi)
        ratio_next = hi;
    end
  endfunction
  // ****************************************************************
  // statistics area per algorithm
  // ****************************************************************
  // region flag use
  wire [11:0] ae_x0 = reg_en_q[0] ? reg_left_q[0] : 12'h000;
  wire [11:0] ae_y0 = reg_en_q[0] ? reg_top_q[0]  : 12'h000;
  wire [11:0] ae_w  = reg_en_q[0] ? reg_cols_q[0] : frame_cols_q;
  wire [11:0] ae_h  = reg_en_q[0] ? reg_rows_q[0] : frame_rows_q;
  wire [11:0] wb_x0 = reg_en_q[1] ? reg_left_q[1] : 12'h000;
  wire [11:0] wb_y0 = reg_en_q[1] ? reg_top_q[1]  : 12'h000;
  wire [11:0] wb_w  = reg_en_q[1] ? reg_cols_q[1] : frame_cols_q;
  wire [11:0] wb_h  = reg_en_q[1] ? reg_rows_q[1] : frame_rows_q;
  // spot window about 1/6 by 1/6
  wire [11:0] spot_w  = frac(ae_w, `AEWB_SPOT_MUL);
  wire [11:0] spot_h  = frac(ae_h, `AEWB_SPOT_MUL);
  // partial window about 1/3 by 1/3
  wire [11:0] part_w  = frac(ae_w, `AEWB_PART_MUL);
  wire [11:0] part_h  = frac(ae_h, `AEWB_PART_MUL);
  wire [11:0] spot_x0 = ae_x0 + {1'b0, ae_w[11:1]} - {1'b0, spot_w[11:1]};
  wire [11:0] spot_y0 = ae_y0 + {1'b0, ae_h[11:1]} - {1'b0, spot_h[11:1]};
  wire [11:0] part_x0 = ae_x0 + {1'b0, ae_w[11:1]} - {1'b0, part_w[11:1]};
  wire [11:0] part_y0 = ae_y0 + {1'b0, ae_h[11:1]} - {1'b0, part_h[11:1]};
  wire in_ae   = in_win(pix_x_i, pix_y_i, ae_x0, ae_y0, ae_w, ae_h);
  wire in_spot = in_win(pix_x_i, pix_y_i, spot_x0, spot_y0, spot_w, spot_h);
  wire in_part = in_win(pix_x_i, pix_y_i, part_x0, part_y0, part_w, part_h);
  wire in_wb   = in_win(pix_x_i, pix_y_i, wb_x0, wb_y0, wb_w, wb_h);
  wire [9:0] luma_sum = {2'h0, pix_r_i} + {1'b0, pix_g_i, 1'b0} +
                        {2'h0, pix_b_i};
  wire [7:0] luma = luma_sum[9:2];
  // ****************************************************************
  // metering weight
  // ****************************************************************
  reg [2:0] meter_eff;
  reg [1:0] weight;
  always @* begin
    case (light_q)
      `AEWB_LIGHT_BACK:  meter_eff = `AEWB_METER_PARTIAL;
      `AEWB_LIGHT_FRONT: meter_eff = `AEWB_METER_SPOT;
      default:           meter_eff = meter_q;
    endcase
    case (meter_eff)
      `AEWB_METER_AVERAGE: weight = {1'b0, in_ae};
      `AEWB_METER_SPOT:    weight = {1'b0, in_spot};
      `AEWB_METER_PARTIAL: weight = {1'b0, in_part};
      `AEWB_METER_CENTRE:  weight = {1'b0, in_ae} + {1'b0, in_part};
      `AEWB_METER_HISTTOP: weight = {1'b0, in_ae & (luma >= `AEWB_HIST_LEVEL)};
      default:             weight = {1'b0, in_ae};
    endcase
  end
  // ****************************************************************
  // target selection
  // ****************************************************************
  reg [6:0] tgt_auto;
  reg [6:0] tgt_sel;
  always @* begin
    case (light_q)
      `AEWB_LIGHT_BACK:  tgt_auto = `AEWB_TGT_AUTO_BACK;
      `AEWB_LIGHT_FRONT: tgt_auto = `AEWB_TGT_AUTO_FRONT;
      default:           tgt_auto = `AEWB_TGT_AUTO_NORM;
    endcase
    if (tgt_auto < tgt_min_q)
      tgt_auto = tgt_min_q;
    if (tgt_auto > tgt_max_q)
      tgt_auto = tgt_max_q;
    tgt_sel = selfset_q ? tgt_auto : target_q;
  end
  // ****************************************************************
  // exposure loop decision
  // ****************************************************************
  // sum*100 against target*255*count
  wire [41:0] lhs = ae_sum_q * `AEWB_PERCENT;
  wire [41:0] rhs = tgt_sel * `AEWB_FULL_SCALE * ae_cnt_q;
  wire        too_dark   = (ae_cnt_q != 26'h0) && (lhs < rhs);
  wire        too_bright = (ae_cnt_q != 26'h0) && (lhs > rhs);
  wire [19:0] exp_step   = {3'h0, exposure_o[19:3]} + 20'h00001;
  wire [20:0] exp_up     = {1'b0, exposure_o} + {1'b0, exp_step};
  wire [20:0] exp_dn     = {1'b0, exposure_o} - {1'b0, exp_step};
  reg  [19:0] exp_d;
  reg  [8:0]  gain_d;
  always @* begin
    exp_d  = exposure_o;
    gain_d = gain_o;
    if (too_dark) begin
      if (exposure_o < exp_max_q)
        exp_d = exp_up[20] ? exp_max_q : exp_up[19:0];
      else
        gain_d = gain_o + 9'h001;
    end else if (too_bright) begin
      if (gain_o > gain_min_q)
        gain_d = gain_o - 9'h001;
      else
        exp_d = exp_dn[20] ? exp_min_q : exp_dn[19:0];
    end
    if (exp_d > exp_max_q)
      exp_d = exp_max_q;
    if (exp_d < exp_min_q)
      exp_d = exp_min_q;
    if (gain_d > gain_max_q)
      gain_d = gain_max_q;
    if (gain_d < gain_min_q)
      gain_d = gain_min_q;
  end
  // ****************************************************************
  // colour loop decision
  // ****************************************************************
  // step halves per damping unit
  wire [11:0] wb_step = (`AEWB_RATIO_STEP >> damping_q) | 12'h001;
  // outdoor aims red lower, blue higher
  wire [31:0] g_red  = profile_q ? g_sum_q - {4'h0, g_sum_q[31:4]} : g_sum_q;
  wire [31:0] g_blue = profile_q ? g_sum_q + {4'h0, g_sum_q[31:4]} : g_sum_q;
  wire [11:0] red_d  = ratio_next(red_ratio_o, wb_step, ratio_min_q,
    ratio_max_q, r_sum_q < g_red, r_sum_q > g_red);
  wire [11:0] blue_d = ratio_next(blue_ratio_o, wb_step, ratio_min_q,
    ratio_max_q, b_sum_q < g_blue, b_sum_q > g_blue);
  // ****************************************************************
  // accumulation and loop update
  // ****************************************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ae_sum_q     <= 34'h0;
      ae_cnt_q     <= 26'h0;
      r_sum_q      <= 32'h0;
      g_sum_q      <= 32'h0;
      b_sum_q      <= 32'h0;
      exposure_o   <= `AEWB_RST_EXP;
      gain_o       <= `AEWB_RST_GAIN;
      red_ratio_o  <= `AEWB_RST_RATIO;
      blue_ratio_o <= `AEWB_RST_RATIO;
      tgt_now_q    <= `AEWB_RST_TARGET;
      update_o     <= 1'b0;
    end else begin
      update_o <= frame_end_i;
      if (frame_end_i) begin
        exposure_o   <= exp_d;
        gain_o       <= gain_d;
        red_ratio_o  <= red_d;
        blue_ratio_o <= blue_d;
        tgt_now_q    <= tgt_sel;
        ae_sum_q     <= 34'h0;
        ae_cnt_q     <= 26'h0;
        r_sum_q      <= 32'h0;
        g_sum_q      <= 32'h0;
        b_sum_q      <= 32'h0;
      end else if (pix_valid_i) begin
        ae_sum_q <= ae_sum_q + luma * weight;
        ae_cnt_q <= ae_cnt_q + {24'h0, weight};
        if (in_wb) begin
          r_sum_q <= r_sum_q + {24'h0, pix_r_i};
          g_sum_q <= g_sum_q + {24'h0, pix_g_i};
          b_sum_q <= b_sum_q + {24'h0, pix_b_i};
        end
      end
    end
  end
  // ****************************************************************
  // register writes
  // ****************************************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_q        <= `AEWB_SEL_EXPOSURE;
      selfset_q    <= 1'b0;
      profile_q    <= 1'b0;
      light_q      <= `AEWB_LIGHT_NORMAL;
      meter_q      <= `AEWB_METER_AVERAGE;
      frame_cols_q <= `AEWB_RST_FRAME_COLS;
      frame_rows_q <= `AEWB_RST_FRAME_ROWS;
      ratio_min_q  <= `AEWB_RST_RATIO_MIN;
      ratio_max_q  <= `AEWB_RST_RATIO_MAX;
      damping_q    <= `AEWB_RST_DAMPING;
      target_q     <= `AEWB_RST_TARGET;
      tgt_min_q    <= `AEWB_RST_TGT_MIN;
      tgt_max_q    <= `AEWB_RST_TGT_MAX;
      exp_min_q    <= `AEWB_RST_EXP_MIN;
      exp_max_q    <= `AEWB_RST_EXP_MAX;
      gain_min_q   <= `AEWB_RST_GAIN_MIN;
      gain_max_q   <= `AEWB_RST_GAIN_MAX;
      for (i = 0; i < 2; i = i + 1) begin
        reg_en_q[i]   <= 1'b0;
        reg_left_q[i] <= 12'h000;
        reg_top_q[i]  <= 12'h000;
        reg_cols_q[i] <= `AEWB_RST_FRAME_COLS;
        reg_rows_q[i] <= `AEWB_RST_FRAME_ROWS;
      end
    end else if (wr_take) begin
      case (avs_address_i)
        `AEWB_REG_CTRL: begin
          sel_q     <= avs_writedata_i[`AEWB_CTRL_SEL];
          selfset_q <= avs_writedata_i[`AEWB_CTRL_SELFSET];
          profile_q <= avs_writedata_i[`AEWB_CTRL_PROFILE];
          light_q   <= avs_writedata_i[`AEWB_CTRL_LIGHT_HI:`AEWB_CTRL_LIGHT_LO];
          meter_q   <= avs_writedata_i[`AEWB_CTRL_METER_HI:`AEWB_CTRL_METER_LO];
        end
        `AEWB_REG_REGION_EN: reg_en_q[sel_q]   <= avs_writedata_i[0];
        `AEWB_REG_LEFT:      reg_left_q[sel_q] <= avs_writedata_i[11:0];
        `AEWB_REG_TOP:       reg_top_q[sel_q]  <= avs_writedata_i[11:0];
        `AEWB_REG_COLS:      reg_cols_q[sel_q] <= avs_writedata_i[11:0];
        `AEWB_REG_ROWS:      reg_rows_q[sel_q] <= avs_writedata_i[11:0];
        `AEWB_REG_FRAME: begin
          frame_cols_q <= avs_writedata_i[11:0];
          frame_rows_q <= avs_writedata_i[27:16];
        end
        `AEWB_REG_RATIO_MIN: ratio_min_q <= avs_writedata_i[11:0];
        `AEWB_REG_RATIO_MAX: ratio_max_q <= avs_writedata_i[11:0];
        `AEWB_REG_DAMPING:   damping_q   <= avs_writedata_i[2:0];
        `AEWB_REG_TARGET:    target_q    <= avs_writedata_i[6:0];
        `AEWB_REG_TGT_MIN:   tgt_min_q   <= avs_writedata_i[6:0];
        `AEWB_REG_TGT_MAX:   tgt_max_q   <= avs_writedata_i[6:0];
        `AEWB_REG_EXP_MIN:   exp_min_q   <= avs_writedata_i[19:0];
        `AEWB_REG_EXP_MAX:   exp_max_q   <= avs_writedata_i[19:0];
        `AEWB_REG_GAIN_MIN:  gain_min_q  <= avs_writedata_i[8:0];
        `AEWB_REG_GAIN_MAX:  gain_max_q  <= avs_writedata_i[8:0];
        default: ;
      endcase
    end
  end
  // ****************************************************************
  // register reads and waitrequest
  // ****************************************************************
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    case (avs_address_i)
      `AEWB_REG_CTRL:      rd_mux = {24'h0, meter_q, light_q, profile_q,
                                     selfset_q, sel_q};
      `AEWB_REG_REGION_EN: rd_mux = {31'h0, reg_en_q[sel_q]};
      `AEWB_REG_LEFT:      rd_mux = {20'h0, reg_left_q[sel_q]};
      `AEWB_REG_TOP:       rd_mux = {20'h0, reg_top_q[sel_q]};
      `AEWB_REG_COLS:      rd_mux = {20'h0, reg_cols_q[sel_q]};
      `AEWB_REG_ROWS:      rd_mux = {20'h0, reg_rows_q[sel_q]};
      `AEWB_REG_FRAME:     rd_mux = {4'h0, frame_rows_q, 4'h0, frame_cols_q};
      `AEWB_REG_RATIO_MIN: rd_mux = {20'h0, ratio_min_q};
      `AEWB_REG_RATIO_MAX: rd_mux = {20'h0, ratio_max_q};
      `AEWB_REG_DAMPING:   rd_mux = {29'h0, damping_q};
      `AEWB_REG_TARGET:    rd_mux = {25'h0, target_q};
      `AEWB_REG_TGT_MIN:   rd_mux = {25'h0, tgt_min_q};
      `AEWB_REG_TGT_MAX:   rd_mux = {25'h0, tgt_max_q};
      `AEWB_REG_EXP_MIN:   rd_mux = {12'h0, exp_min_q};
      `AEWB_REG_EXP_MAX:   rd_mux = {12'h0, exp_max_q};
      `AEWB_REG_GAIN_MIN:  rd_mux = {23'h0, gain_min_q};
      `AEWB_REG_GAIN_MAX:  rd_mux = {23'h0, gain_max_q};
      `AEWB_REG_EXP_NOW:   rd_mux = {12'h0, exposure_o};
      `AEWB_REG_GAIN_NOW:  rd_mux = {23'h0, gain_o};
      `AEWB_REG_RATIO_NOW: rd_mux = {4'h0, blue_ratio_o, 4'h0, red_ratio_o};
      `AEWB_REG_TGT_NOW:   rd_mux = {25'h0, tgt_now_q};
      default:             rd_mux = 32'h0;
    endcase
  end
  // one wait state, then one cycle with waitrequest low
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else begin
      if (rd_take | wr_take)
        avs_waitrequest_o <= 1'b1;
      else if (avs_read_i | avs_write_i)
        avs_waitrequest_o <= 1'b0;
      if (avs_read_i & avs_waitrequest_o)
        avs_readdata_o <= rd_mux;
    end
  end
endmodule // aewb_ctrl

// file: hdl/aewb_defines.vh
// Constants for the exposure and colour-balance region/statistics block.
// Assumes a 125 MHz single-clock system and 32-bit Avalon-MM access.
`ifndef AEWB_DEFINES_VH
`define AEWB_DEFINES_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define AEWB_REG_CTRL       7'h00
`define AEWB_REG_REGION_EN  7'h04
`define AEWB_REG_LEFT       7'h08
`define AEWB_REG_TOP        7'h0C
`define AEWB_REG_COLS       7'h10
`define AEWB_REG_ROWS       7'h14
`define AEWB_REG_FRAME      7'h18
`define AEWB_REG_RATIO_MIN  7'h1C
`define AEWB_REG_RATIO_MAX  7'h20
`define AEWB_REG_DAMPING    7'h24
`define AEWB_REG_TARGET     7'h28
`define AEWB_REG_TGT_MIN    7'h2C
`define AEWB_REG_TGT_MAX    7'h30
`define AEWB_REG_EXP_MIN    7'h34
`define AEWB_REG_EXP_MAX    7'h38
`define AEWB_REG_GAIN_MIN   7'h3C
`define AEWB_REG_GAIN_MAX   7'h40
`define AEWB_REG_EXP_NOW    7'h44
`define AEWB_REG_GAIN_NOW   7'h48
`define AEWB_REG_RATIO_NOW  7'h4C
`define AEWB_REG_TGT_NOW    7'h50

// ****************************************************************
// control register fields
// ****************************************************************
`define AEWB_CTRL_SEL       0
`define AEWB_CTRL_SELFSET   1
`define AEWB_CTRL_PROFILE   2
`define AEWB_CTRL_LIGHT_LO  3
`define AEWB_CTRL_LIGHT_HI  4
`define AEWB_CTRL_METER_LO  5
`define AEWB_CTRL_METER_HI  7

`define AEWB_SEL_EXPOSURE   1'h0
`define AEWB_SEL_COLOUR     1'h1
`define AEWB_LIGHT_NORMAL   2'h0
`define AEWB_LIGHT_BACK     2'h1
`define AEWB_LIGHT_FRONT    2'h2
`define AEWB_METER_AVERAGE  3'h0
`define AEWB_METER_SPOT     3'h1
`define AEWB_METER_PARTIAL  3'h2
`define AEWB_METER_CENTRE   3'h3
`define AEWB_METER_HISTTOP  3'h4

// ****************************************************************
// reset values
// ****************************************************************
`define AEWB_RST_FRAME_COLS 12'h500
`define AEWB_RST_FRAME_ROWS 12'h400
`define AEWB_RST_RATIO      12'h400
`define AEWB_RST_RATIO_MIN  12'h100
`define AEWB_RST_RATIO_MAX  12'hFFF
`define AEWB_RST_DAMPING    3'h3
`define AEWB_RST_TARGET     7'h32
`define AEWB_RST_TGT_MIN    7'h0A
`define AEWB_RST_TGT_MAX    7'h5A
`define AEWB_RST_EXP        20'h01388
`define AEWB_RST_EXP_MIN    20'h0000A
`define AEWB_RST_EXP_MAX    20'h7A120
`define AEWB_RST_GAIN       9'h000
`define AEWB_RST_GAIN_MIN   9'h000
`define AEWB_RST_GAIN_MAX   9'h0F0

// ****************************************************************
// loop constants
// ****************************************************************
`define AEWB_TGT_AUTO_NORM  7'h2D
`define AEWB_TGT_AUTO_BACK  7'h37
`define AEWB_TGT_AUTO_FRONT 7'h28
`define AEWB_FULL_SCALE     8'hFF
`define AEWB_PERCENT        7'h64
`define AEWB_HIST_LEVEL     8'h80
`define AEWB_RATIO_STEP     12'h040
// centre windows: 43/256 of a side is about 1/6, 85/256 about 1/3
`define AEWB_SPOT_MUL       7'h2B
`define AEWB_PART_MUL       7'h55

`endif

// file: testbench/aewb_ctrl_assertions.sv
// concurrent checks on the aewb_ctrl ports
// bound into every aewb_ctrl; limits are mirrored from bus writes
`include "aewb_defines.vh"
module aewb_ctrl_assertions (
  input wire        mclk_i,
  input wire        rst_n_i,
  input wire [6:0]  avs_address_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire        avs_waitrequest_o,
  input wire        frame_end_i,
  input wire [19:0] exposure_o,
  input wire [8:0]  gain_o,
  input wire [11:0] red_ratio_o,
  input wire [11:0] blue_ratio_o,
  input wire        update_o
);
  reg [19:0] emin_q, emax_q;
  reg [8:0]  gmin_q, gmax_q;
  reg [11:0] rmin_q, rmax_q;
  // ****************************************
  // limit mirror
  // ****************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      emin_q <= `AEWB_RST_EXP_MIN;
      emax_q <= `AEWB_RST_EXP_MAX;
      gmin_q <= `AEWB_RST_GAIN_MIN;
      gmax_q <= `AEWB_RST_GAIN_MAX;
      rmin_q <= `AEWB_RST_RATIO_MIN;
      rmax_q <= `AEWB_RST_RATIO_MAX;
    end else if (avs_write_i && !avs_waitrequest_o) begin
      case (avs_address_i)
        `AEWB_REG_EXP_MIN:   emin_q <= avs_writedata_i[19:0];
        `AEWB_REG_EXP_MAX:   emax_q <= avs_writedata_i[19:0];
        `AEWB_REG_GAIN_MIN:  gmin_q <= avs_writedata_i[8:0];
        `AEWB_REG_GAIN_MAX:  gmax_q <= avs_writedata_i[8:0];
        `AEWB_REG_RATIO_MIN: rmin_q <= avs_writedata_i[11:0];
        `AEWB_REG_RATIO_MAX: rmax_q <= avs_writedata_i[11:0];
        default: ;
      endcase
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  chk_exp_range:
    assert property (update_o |-> exposure_o >= emin_q &&
      exposure_o <= emax_q) else $error("exposure outside limits");
  chk_gain_range:
    assert property (update_o |-> gain_o >= gmin_q && gain_o <= gmax_q)
      else $error("gain outside limits");
  chk_ratio_range:
    assert property (update_o |-> red_ratio_o >= rmin_q &&
      red_ratio_o <= rmax_q && blue_ratio_o >= rmin_q &&
      blue_ratio_o <= rmax_q) else $error("ratio outside limits");
  chk_ratio_hold:
    assert property (!update_o |-> $stable(red_ratio_o) &&
      $stable(blue_ratio_o)) else $error("ratio moved between frames");
  chk_exp_hold:
    assert property (!update_o |-> $stable(exposure_o) && $stable(gain_o))
      else $error("exposure moved between frames");
  chk_update_cause:
    assert property (update_o |-> $past(frame_end_i))
      else $error("update without frame end");
  chk_update_follow:
    assert property (frame_end_i |=> update_o)
      else $error("frame end without update");
  chk_wait_one:
    assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
      else $error("wait low over one cycle");
endmodule // aewb_ctrl_assertions
bind aewb_ctrl aewb_ctrl_assertions u_chk (.mclk_i, .rst_n_i,
  .avs_address_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o,
  .frame_end_i, .exposure_o, .gain_o, .red_ratio_o, .blue_ratio_o,
  .update_o);

// file: testbench/testbench.sv
// self-checking bench for aewb_ctrl
// drives the register bus and a 24x24 pixel frame directly
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i, rst_n_i, rd, wr, pv, fe, wt, upd;
  logic [6:0]  adr;
  logic [31:0] wd, ro, rdata;
  logic [11:0] px, py;
  logic [7:0]  pr, pg, pb;
  logic [19:0] exp_v, e0;
  logic [8:0]  gn;
  int          n_mismatch, checks_done;
  // op nibble: 0 read and compare, 1 write, 2 frame
  logic [43:0] rows [$] = {44'h000_00000000, 44'h01C_00000100,
    44'h020_00000FFF, 44'h02C_0000000A, 44'h030_0000005A,
    44'h034_0000000A, 44'h038_0007A120, 44'h040_000000F0,
    44'h04C_04000400, 44'h07C_00000000, 44'h108_00000005,
    44'h100_00000001, 44'h108_00000009, 44'h104_00000001,
    44'h004_00000001, 44'h100_00000000, 44'h008_00000005,
    44'h004_00000000, 44'h100_00000001, 44'h008_00000009,
    44'h104_00000000, 44'h118_00180018, 44'h100_00000000,
    44'h124_00000000, 44'h200_0000C8C8, 44'h04C_04000441,
    44'h124_00000006, 44'h200_0000C8C8, 44'h04C_04000442,
    44'h120_00000444, 44'h124_00000000, 44'h200_0000C8C8,
    44'h04C_04000444, 44'h100_00000004, 44'h200_0000C8C8,
    44'h04C_04410444, 44'h100_00000002, 44'h200_00C8C8C8,
    44'h050_0000002D, 44'h12C_00000032, 44'h200_00C8C8C8,
    44'h050_00000032, 44'h12C_0000000A, 44'h130_0000001E,
    44'h200_00C8C8C8, 44'h050_0000001E, 44'h100_00000000,
    44'h128_00000005, 44'h200_00C8C8C8, 44'h050_00000005};
  // bit 8 set: exposure must fall on the centre-lit frame
  logic [8:0]  mt [7] = '{9'h000, 9'h120, 9'h140, 9'h060, 9'h180,
    9'h108, 9'h110};

  aewb_ctrl dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(ro), .avs_waitrequest_o(wt), .pix_valid_i(pv),
    .pix_x_i(px), .pix_y_i(py), .pix_r_i(pr), .pix_g_i(pg), .pix_b_i(pb),
    .frame_end_i(fe), .exposure_o(exp_v), .gain_o(gn), .red_ratio_o(),
    .blue_ratio_o(), .update_o(upd));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    int k;
    k = 0;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge mclk_i);
    while (wt !== 1'b0 && k < 50) begin
      @(posedge mclk_i);
      k++;
    end
    rdata = ro;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask

  // d: [7:0] outer grey, [15:8] centre grey, [23:16] outer red
  task frame(input logic [31:0] d);
    logic c;
    for (int y = 0; y < 24; y++) begin
      for (int x = 0; x < 24; x++) begin
        c = (x == 11 || x == 12) && (y == 11 || y == 12);
        pv <= 1'b1;
        px <= 12'(x);
        py <= 12'(y);
        pg <= c ? d[15:8] : d[7:0];
        pb <= c ? d[15:8] : d[7:0];
        pr <= c ? d[15:8] : d[23:16];
        @(posedge mclk_i);
      end
    end
    pv <= 1'b0;
    fe <= 1'b1;
    @(posedge mclk_i);
    fe <= 1'b0;
    @(posedge mclk_i);
    chk({31'h0, upd}, 32'h1);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #600_000;
    n_mismatch++;
    final_report;
  end

  initial begin
    {rst_n_i, rd, wr, pv, fe, adr, wd, px, py, pr, pg, pb} = '0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    foreach (rows[i]) begin
      if (rows[i][43:40] == 4'h2) frame(rows[i][31:0]);
      else bus(rows[i][40], rows[i][38:32], rows[i][31:0]);
      if (rows[i][43:40] == 4'h0) chk(rdata, rows[i][31:0]);
    end
    $display("table done");
    foreach (mt[i]) begin
      bus(1'b1, 7'h00, {24'h0, mt[i][7:0]});
      e0 = exp_v;
      frame(32'h0000FF00);
      chk({31'h0, exp_v < e0}, {31'h0, mt[i][8]});
    end
    $display("metering done");
    bus(1'b1, 7'h38, 32'h0000_1400);
    bus(1'b1, 7'h40, 32'h0000_0010);
    for (int i = 0; i < 40 && gn !== 9'h010; i++) frame(32'h0);
    chk({12'h0, exp_v}, 32'h0000_1400);
    chk({23'h0, gn}, 32'h0000_0010);
    $display("limits done");
    rst_n_i <= 1'b0;
    @(posedge mclk_i);
    chk({12'h0, exp_v}, 32'h0000_1388);
    chk({31'h0, wt}, 32'h1);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    bus(1'b0, 7'h00, 32'h0);
    chk(rdata, 32'h0);
    $display("reset done");
    final_report;
  end
endmodule // testbench
